// ===== core/cap_timer_pkg.sv
// shared constants and types for the capture / pwm timer with dma
package cap_timer_pkg;
   // =====================================================
   // widths
   localparam int DIV_W = 8;
   localparam int CNT_W = 16;
   localparam int WIDTH_W = 15;
   localparam int DMA_CNT_W = 8;
   localparam int DMA_ADDR_W = 12;
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 16;
   // =====================================================
   // capture word layout
   localparam int WORD_FLAG_BIT = 15;
   // =====================================================
   // dma address layout: low byte keeps bits 7..1, high byte keeps bits 3..0
   localparam int ADDR_LOW_MSB = 7;
   localparam int ADDR_LOW_LSB = 1;
   localparam int ADDR_HIGH_MSB = 3;
   localparam logic [DMA_ADDR_W-1:0] DMA_ADDR_STEP = 12'h002;
   // =====================================================
   // minimum accepted pulse width in divided clocks
   localparam logic [2:0] MINW_SLOW_TICKS = 3'h4;
   localparam logic [2:0] MINW_FAST_TICKS = 3'h1;
   // =====================================================
   // reset values
   localparam logic CLEAR_ALL_RESET = 1'b1;
   localparam logic [DIV_W-1:0] DIVISOR_RESET = 8'h01;
   // =====================================================
   // edge select field
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_ANY = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_RISE = 2'b11
   } edge_mode_t;
endpackage : cap_timer_pkg

// ===== core/sample_fifo.sv
// parameterised fifo whose read data come out of a register
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   // filling side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // draining side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] used_r;
   logic valid_r;
   logic [WIDTH-1:0] data_r;
   wire push = in_valid_i & in_ready_o;
   wire load = (used_r != '0) & (~valid_r | out_ready_i);
   // full is exact on the storage count; empty follows the output register
   assign in_ready_o = (used_r != (AW+1)'(DEPTH));
   assign out_valid_o = valid_r;
   assign out_data_o = data_r;
   // storage array has no reset; only pointers matter
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end
   // pointers, count and the output register
   always_ff @(posedge clk_i) begin
      if (!resetn_i || flush_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         used_r <= '0;
         valid_r <= 1'b0;
         data_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (load) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
            data_r <= mem_r[rd_ptr_r];
            valid_r <= 1'b1;
         end else if (out_ready_i) begin
            valid_r <= 1'b0;
         end
         used_r <= used_r + (AW+1)'(push) - (AW+1)'(load);
      end
   end
endmodule : sample_fifo
`default_nettype wire

// ===== core/capture_pwm_timer_dma.sv
// 16-bit timer with edge-width capture, sample fifo and dma drain
`timescale 1ns/100ps
`default_nettype none
module capture_pwm_timer_dma (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // capture pin, asynchronous
   input wire logic cap_pin_i,
   // divisor setup
   input wire logic divisor_write_enable_i,
   input wire logic [7:0] clock_divisor_i,
   input wire logic [15:0] end_value_i,
   // control register bits
   input wire logic capture_mode_select_i,
   input wire logic edge_select_high_i,
   input wire logic edge_select_low_i,
   input wire logic min_pulse_width_select_i,
   input wire logic count_enable_i,
   input wire logic clear_all_wr_i,
   input wire logic clear_all_wdata_i,
   output logic clear_all_o,
   // dma setup
   input wire logic dma_enable_i,
   input wire logic dma_address_low_wr_i,
   input wire logic [7:0] dma_address_low_i,
   input wire logic dma_address_high_wr_i,
   input wire logic [7:0] dma_address_high_i,
   input wire logic dma_word_count_wr_i,
   input wire logic [7:0] dma_word_count_i,
   // dma master side
   output logic dma_req_o,
   output logic [11:0] dma_addr_o,
   output logic [15:0] dma_data_o,
   input wire logic dma_ack_i,
   output logic [7:0] dma_word_count_o,
   // software fifo read
   output logic fifo_rd_valid_o,
   output logic [15:0] fifo_rd_data_o,
   input wire logic fifo_rd_ready_i,
   // status
   output logic capture_ready_o,
   output logic [15:0] count_o,
   output logic timer_wrap_o
);
   // =====================================================
   // registers
   logic pin_s1_r;
   logic pin_s2_r;
   logic [7:0] divisor_r;
   logic [7:0] div_cnt_r;
   logic clear_all_r;
   logic filt_r;
   logic [1:0] filt_cnt_r;
   logic [15:0] count_r;
   logic first_r;
   logic [11:0] dma_addr_r;
   logic [7:0] dma_cnt_r;
   logic wrap_r;
   // =====================================================
   // divided clock enable
   wire tick = ({1'b0, div_cnt_r} + 9'h001) >= {1'b0, divisor_r};
   wire [1:0] edge_sel = {edge_select_high_i, edge_select_low_i};
   wire cap_active = capture_mode_select_i & count_enable_i & ~clear_all_r
                     & (edge_sel != cap_timer_pkg::EDGE_NONE);
   wire tmr_active = ~capture_mode_select_i & count_enable_i & ~clear_all_r;
   // =====================================================
   // glitch filter and edge qualification
   wire [2:0] need = min_pulse_width_select_i ? cap_timer_pkg::MINW_FAST_TICKS
                                              : cap_timer_pkg::MINW_SLOW_TICKS;
   wire differ = (pin_s2_r != filt_r);
   wire accept = tick & differ & ({1'b0, filt_cnt_r} == (need - 3'h1));
   wire rise = accept & pin_s2_r;
   wire fall = accept & ~pin_s2_r;
   wire valid_edge = cap_active & ((edge_sel == cap_timer_pkg::EDGE_ANY) & accept
                     | (edge_sel == cap_timer_pkg::EDGE_RISE) & rise
                     | (edge_sel == cap_timer_pkg::EDGE_FALL) & fall);
   // =====================================================
   // width measurement and word forming
   wire [14:0] width = count_r[14:0] + 15'h0001;
   wire any_mode = (edge_sel == cap_timer_pkg::EDGE_ANY);
   wire ovf = cap_active & tick & ~valid_edge & (width == end_value_i[14:0]);
   wire word_fire = valid_edge | ovf;
   wire flag = any_mode ? filt_r : ovf;
   wire [15:0] word = {flag, width};
   wire push = word_fire & ~first_r;
   // =====================================================
   // fifo drain steering: dma owns the fifo while it has words left to move
   wire out_valid;
   wire [15:0] out_data;
   wire dma_active = dma_enable_i & (dma_cnt_r != 8'h00);
   wire out_ready = dma_active ? dma_ack_i : fifo_rd_ready_i;
   wire dma_fire = dma_active & out_valid & dma_ack_i;
   assign dma_req_o = dma_active & out_valid;
   assign fifo_rd_valid_o = ~dma_active & out_valid;
   assign dma_data_o = out_data;
   assign fifo_rd_data_o = out_data;
   assign dma_addr_o = dma_addr_r;
   assign dma_word_count_o = dma_cnt_r;
   assign clear_all_o = clear_all_r;
   assign count_o = count_r;
   assign timer_wrap_o = wrap_r;

   sample_fifo #(
      .WIDTH(cap_timer_pkg::FIFO_WIDTH),
      .DEPTH(cap_timer_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .flush_i(clear_all_r),
      .in_valid_i(push),
      .in_data_i(word),
      .in_ready_o(capture_ready_o),
      .out_valid_o(out_valid),
      .out_data_o(out_data),
      .out_ready_i(out_ready)
   );
   // =====================================================
   // pin synchroniser
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= cap_pin_i;
         pin_s2_r <= pin_s1_r;
      end
   end
   // divisor latch and prescaler; a divisor of 0 or 1 ticks every cycle
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         divisor_r <= cap_timer_pkg::DIVISOR_RESET;
         div_cnt_r <= 8'h00;
      end else begin
         if (divisor_write_enable_i) divisor_r <= clock_divisor_i;
         div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
      end
   end
   // clear-all comes up set so nothing runs until software releases it
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         clear_all_r <= cap_timer_pkg::CLEAR_ALL_RESET;
      end else if (clear_all_wr_i) begin
         clear_all_r <= clear_all_wdata_i;
      end
   end
   // filter: level must differ for the chosen number of ticks
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || clear_all_r) begin
         filt_r <= 1'b0;
         filt_cnt_r <= 2'h0;
      end else if (tick) begin
         if (accept) begin
            filt_r <= pin_s2_r;
            filt_cnt_r <= 2'h0;
         end else begin
            filt_cnt_r <= differ ? filt_cnt_r + 2'h1 : 2'h0;
         end
      end
   end
   // shared counter: free timer or width measurement
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || clear_all_r) begin
         count_r <= 16'h0000;
         wrap_r <= 1'b0;
      end else begin
         wrap_r <= 1'b0;
         if (word_fire) begin
            count_r <= 16'h0000;
         end else if (cap_active && tick) begin
            count_r <= {1'b0, width};
         end else if (tmr_active && tick) begin
            wrap_r <= (count_r == end_value_i);
            count_r <= (count_r == end_value_i) ? 16'h0000 : count_r + 16'h0001;
         end
      end
   end
   // the span before the first word has no opening edge, so skip it
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || !cap_active) begin
         first_r <= 1'b1;
      end else if (word_fire) begin
         first_r <= 1'b0;
      end
   end
   // dma pointer and count; a software load in the same cycle wins
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         dma_addr_r <= 12'h000;
         dma_cnt_r <= 8'h00;
      end else begin
         if (dma_address_low_wr_i) begin
            dma_addr_r[7:0] <= {dma_address_low_i[7:1], 1'b0};
         end else if (dma_fire) begin
            dma_addr_r <= dma_addr_r + cap_timer_pkg::DMA_ADDR_STEP;
         end
         if (dma_address_high_wr_i) dma_addr_r[11:8] <= dma_address_high_i[3:0];
         if (dma_word_count_wr_i) begin
            dma_cnt_r <= dma_word_count_i;
         end else if (dma_fire) begin
            dma_cnt_r <= dma_cnt_r - 8'h01;
         end
      end
   end
   // =====================================================
   // assertions
   property p_tick_rate;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (divisor_r > 8'h01) && tick && !divisor_write_enable_i |=> !tick;
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("divided tick repeated too soon");

   property p_clear_holds;
      @(posedge core_clk_i) disable iff (!resetn_i)
      clear_all_r |=> (count_r == 16'h0000) && !out_valid;
   endproperty
   a_clear_holds: assert property (p_clear_holds) else $error("clear-all did not hold state");

   property p_dma_count;
      @(posedge core_clk_i) disable iff (!resetn_i)
      dma_fire && !dma_word_count_wr_i |=> dma_cnt_r == $past(dma_cnt_r) - 8'h01;
   endproperty
   a_dma_count: assert property (p_dma_count) else $error("dma count not decremented");

   property p_dma_addr;
      @(posedge core_clk_i) disable iff (!resetn_i)
      dma_fire && !dma_address_low_wr_i && !dma_address_high_wr_i
      |=> (dma_addr_r == $past(dma_addr_r) + 12'h002) && !dma_addr_r[0];
   endproperty
   a_dma_addr: assert property (p_dma_addr) else $error("dma address not stepped by two");

   property p_first_drop;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $rose(cap_active) |-> first_r && !push;
   endproperty
   a_first_drop: assert property (p_first_drop) else $error("first word not dropped");

   property p_no_capture;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (edge_sel == 2'b00) |-> !push ##1 (count_r == 16'h0000 || !capture_mode_select_i || $past(tmr_active));
   endproperty
   a_no_capture: assert property (p_no_capture) else $error("capture ran with edge select 00");

   property p_rise_only;
      @(posedge core_clk_i) disable iff (!resetn_i)
      valid_edge && (edge_sel == 2'b11) |=> filt_r && !$past(filt_r);
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("non-rising edge taken in mode 11");

   property p_fall_only;
      @(posedge core_clk_i) disable iff (!resetn_i)
      valid_edge && (edge_sel == 2'b10) |=> !filt_r && $past(filt_r);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("non-falling edge taken in mode 10");

   property p_ovf_flag;
      @(posedge core_clk_i) disable iff (!resetn_i)
      word_fire && !any_mode |-> (word[15] == ovf) && (!ovf || word[14:0] == end_value_i[14:0]);
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag wrong");

   property p_level_flag;
      @(posedge core_clk_i) disable iff (!resetn_i)
      valid_edge && any_mode |-> word[15] != pin_s2_r;
   endproperty
   a_level_flag: assert property (p_level_flag) else $error("any-edge level flag wrong");

   property p_restart;
      @(posedge core_clk_i) disable iff (!resetn_i)
      word_fire |=> (count_r == 16'h0000) ##1 (count_r <= 16'h0001);
   endproperty
   a_restart: assert property (p_restart) else $error("width counter did not restart");
endmodule : capture_pwm_timer_dma
`default_nettype wire

// ===== tb/cap_pin_model.sv
// pin-side model: drives the capture input with whole-clock level spans
`timescale 1ns/100ps
`default_nettype none
module cap_pin_model (
   // clock
   input wire logic clk_i,
   // capture pin
   output logic pin_o
);
   // =====================================================
   // idle level
   // a push-pull source: the pin never floats, it idles low between tests
   initial begin
      pin_o = 1'b0;
   end
   // =====================================================
   // span driver
   // changes only just after an edge and holds for exactly the given clocks
   task automatic span(input logic lvl, input int cycles);
      @(posedge clk_i);
      pin_o <= lvl;
      repeat (cycles - 1) @(posedge clk_i);
   endtask : span
endmodule : cap_pin_model
`default_nettype wire

// ===== tb/capture_pwm_timer_dma_tb_top.sv
// self-checking bench for the capture timer with fifo and dma drain
`timescale 1ns/100ps
`default_nettype none
module capture_pwm_timer_dma_tb_top;
   // =====================================================
   // stimulus and observed signals
   logic clk = 1'b0, resetn = 1'b0, pin, div_we = 1'b0, cap_mode = 1'b0, es_h = 1'b0, es_l = 1'b0;
   logic minw = 1'b0, cnt_en = 1'b0, clr_wr = 1'b0, clr_wd = 1'b0, dma_en = 1'b0, al_wr = 1'b0;
   logic ah_wr = 1'b0, cn_wr = 1'b0, dma_ack = 1'b0, rd_ready = 1'b0;
   logic [7:0] divisor = 8'h01, al = 8'h00, ah = 8'h00, cn = 8'h00, dma_cnt;
   logic [15:0] end_val = 16'h0000, dma_data, rd_data, count;
   logic [11:0] dma_addr, exp_addr;
   logic clr_all, dma_req, rd_valid, cap_ready, wrap;
   logic [15:0] exp_q[$];
   int err_total = 0, n_compared = 0;
   // one row per edge mode: select, min width, divisor
   logic [1:0] es_tab [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
   logic mw_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   int d_tab [4] = '{2, 1, 3, 1};
   // =====================================================
   // design and pin model
   capture_pwm_timer_dma i_dut (.core_clk_i(clk), .resetn_i(resetn), .cap_pin_i(pin),
      .divisor_write_enable_i(div_we), .clock_divisor_i(divisor), .end_value_i(end_val),
      .capture_mode_select_i(cap_mode), .edge_select_high_i(es_h), .edge_select_low_i(es_l),
      .min_pulse_width_select_i(minw), .count_enable_i(cnt_en), .clear_all_wr_i(clr_wr),
      .clear_all_wdata_i(clr_wd), .clear_all_o(clr_all), .dma_enable_i(dma_en),
      .dma_address_low_wr_i(al_wr), .dma_address_low_i(al), .dma_address_high_wr_i(ah_wr),
      .dma_address_high_i(ah), .dma_word_count_wr_i(cn_wr), .dma_word_count_i(cn),
      .dma_req_o(dma_req), .dma_addr_o(dma_addr), .dma_data_o(dma_data), .dma_ack_i(dma_ack),
      .dma_word_count_o(dma_cnt), .fifo_rd_valid_o(rd_valid), .fifo_rd_data_o(rd_data),
      .fifo_rd_ready_i(rd_ready), .capture_ready_o(cap_ready), .count_o(count), .timer_wrap_o(wrap));
   cap_pin_model i_pin (.clk_i(clk), .pin_o(pin));
   // =====================================================
   // clock
   initial begin
      forever #5 clk = ~clk;
   end
   // =====================================================
   // comparison and closing
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   // =====================================================
   // result watcher: each word leaving by either port takes the oldest note
   // software ready waits while dma owns the words, so no word is taken twice
   always @(posedge clk) begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         check("fifo word", rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
      end
      if (dma_req === 1'b1 && dma_ack === 1'b1) begin
         check("dma word", dma_data, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
         check("dma address", {4'h0, dma_addr}, {4'h0, exp_addr});
         exp_addr += 12'h002;
      end
      rd_ready <= (exp_q.size() > 0) && !(dma_en && dma_cnt != 8'h00) && ($urandom % 4 != 0);
      dma_ack <= dma_en && !(dma_req && dma_ack) && ($urandom % 2 == 1);
   end
   // =====================================================
   // configuration in the documented order, then teardown with clear-all
   task automatic setup(input logic mode, input logic [1:0] es, input logic mw, input logic [7:0] d,
                        input logic [15:0] e);
      @(posedge clk);
      div_we <= 1'b1;
      divisor <= d;
      end_val <= e;
      cap_mode <= mode;
      {es_h, es_l} <= es;
      minw <= mw;
      @(posedge clk);
      div_we <= 1'b0;
      clr_wr <= 1'b1;
      clr_wd <= 1'b0;
      @(posedge clk);
      clr_wr <= 1'b0;
      cnt_en <= 1'b1;
   endtask : setup
   task automatic drain();
      int w;
      w = 0;
      while (exp_q.size() > 0 && w < 4000) begin
         @(posedge clk);
         w++;
      end
      check("words left", 16'(exp_q.size()), 16'h0000);
   endtask : drain
   task automatic end_test(input string name);
      drain();
      @(posedge clk);
      cnt_en <= 1'b0;
      dma_en <= 1'b0;
      clr_wr <= 1'b1;
      clr_wd <= 1'b1;
      @(posedge clk);
      clr_wr <= 1'b0;
      i_pin.span(1'b0, 6);
      check("clear state", {15'h0000, clr_all}, 16'h0001);
      check("count after clear", count, 16'h0000);
      check("fifo ready after clear", {15'h0000, cap_ready}, 16'h0001);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask : end_test
   // =====================================================
   // alternating spans from a high one; notes the words the design owes
   // spans are whole divided clocks so every edge meets the tick at one phase,
   // and no segment is a multiple of the end value, where edge and wrap would tie
   task automatic run_spans(input int n, input logic [1:0] es, input int d, input int e, input int minlen);
      int acc, len, w;
      logic lvl, seen;
      acc = 0;
      seen = 1'b0;
      for (int i = 0; i <= n; i++) begin
         lvl = (i % 2 == 0);
         if (es == 2'b01 || (es == 2'b11 && lvl) || (es == 2'b10 && !lvl)) begin
            w = acc / d;
            while (seen && es != 2'b01 && w > e) begin
               exp_q.push_back({1'b1, 15'(e)});
               w -= e;
            end
            if (seen) exp_q.push_back({(es == 2'b01) ? !lvl : 1'b0, 15'(w)});
            seen = 1'b1;
            acc = 0;
         end
         len = d * (minlen + $urandom % 12);
         if (((acc + len) / d) % e == 0) len += d;
         i_pin.span(lvl, len);
         acc += len;
      end
   endtask : run_spans
   // =====================================================
   // watchdog, reckoned well above the few thousand cycles the tests need
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
   // =====================================================
   // main sequence
   initial begin
      int w;
      w = $urandom(32'hd277);
      exp_addr = 12'h000;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      check("clear after reset", {15'h0000, clr_all}, 16'h0001);
      check("count after reset", count, 16'h0000);
      // timer mode: wrap period is (end + 1) divided clocks
      setup(1'b0, 2'b00, 1'b0, 8'h03, 16'h0009);
      w = 0;
      while (wrap !== 1'b1 && w < 200) begin @(posedge clk); w++; end
      @(posedge clk);
      w = 1;
      while (wrap !== 1'b1 && w < 200) begin @(posedge clk); w++; end
      check("wrap period", 16'(w), 16'h001E);
      end_test("timer");
      // every edge mode; a short glitch first where four ticks are required
      for (int k = 0; k < 4; k++) begin
         setup(1'b1, es_tab[k], mw_tab[k], 8'(d_tab[k]), 16'h4000);
         if (!mw_tab[k]) begin i_pin.span(1'b1, 2); i_pin.span(1'b0, 12); end
         run_spans(12, es_tab[k], d_tab[k], 16384, 6);
         // only mode 00 owes nothing; other modes may still hold their last word here
         if (es_tab[k] == 2'b00) check("no capture", {15'h0000, rd_valid === 1'b1}, 16'h0000);
         end_test("edge mode");
      end
      // overflow: periods of 28 and more against an end value of 20
      setup(1'b1, 2'b11, 1'b1, 8'h01, 16'h0014);
      run_spans(10, 2'b11, 1, 20, 14);
      end_test("overflow");
      // dma: odd low byte and full high byte must land even and masked
      @(posedge clk);
      {al, ah, cn} <= {8'h35, 8'hF2, 8'h03};
      {al_wr, ah_wr, cn_wr} <= 3'h7;
      @(posedge clk);
      {al_wr, ah_wr, cn_wr} <= 3'h0;
      dma_en <= 1'b1;
      exp_addr = 12'h234;
      setup(1'b1, 2'b11, 1'b1, 8'h01, 16'h4000);
      run_spans(10, 2'b11, 1, 16384, 4);
      drain();
      check("dma count", {8'h00, dma_cnt}, 16'h0000);
      check("dma end address", {4'h0, dma_addr}, 16'h023A);
      end_test("dma");
      finish_test();
   end
endmodule : capture_pwm_timer_dma_tb_top
`default_nettype wire
